// ---- modem_ctl.sv ----
// control-signal sequencer for one wan serial link port
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module modem_ctl #(
   parameter int TICK_CYCLES = modem_ctl_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ri_i,
   input wire logic cd_i,
   input wire logic dsr_i,
   input wire logic l2_timeout_i,
   input wire logic [modem_ctl_pkg::ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic dtr_o,
   output logic rts_o,
   output logic link_up_o,
   output logic alarm_o
);

   localparam int SW = modem_ctl_pkg::SEC_W;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edges

   logic [2:0] pins_s;
   logic ri_s;
   logic cd_s;
   logic dsr_s;
   logic ri_d_ff;
   logic cd_d_ff;
   logic ri_rise;
   logic cd_edge;

   sync2 #(.W(3)) u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .d_i({ri_i, cd_i, dsr_i}),
      .q_o(pins_s)
   );

   assign ri_s = pins_s[2];
   assign cd_s = pins_s[1];
   assign dsr_s = pins_s[0];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ri_d_ff <= 1'b0;
         cd_d_ff <= 1'b0;
      end else begin
         ri_d_ff <= ri_s;
         cd_d_ff <= cd_s;
      end
   end

   assign ri_rise = ri_s && !ri_d_ff;
   assign cd_edge = cd_s != cd_d_ff;

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   logic modem_mode_ff;
   logic sb_mode_ff;
   logic sb_act_ff;
   logic [SW-1:0] wait_sec_ff;
   logic lost_ff;
   logic [31:0] rdata_ff;
   logic alarm_ff;
   modem_ctl_pkg::link_state_t state_ff;
   modem_ctl_pkg::link_state_t nxt_state;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         modem_mode_ff <= modem_ctl_pkg::CTRL_MODEM_RST;
         sb_mode_ff <= modem_ctl_pkg::CTRL_SBMODE_RST;
         sb_act_ff <= modem_ctl_pkg::CTRL_SBACT_RST;
      end else if (wr_i && addr_i == modem_ctl_pkg::CTRL_OFS) begin
         modem_mode_ff <= wdata_i[modem_ctl_pkg::CTRL_MODEM_BIT];
         sb_mode_ff <= wdata_i[modem_ctl_pkg::CTRL_SBMODE_BIT];
         sb_act_ff <= wdata_i[modem_ctl_pkg::CTRL_SBACT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_sec_ff <= modem_ctl_pkg::WAIT_SEC_RST;
      end else if (wr_i && addr_i == modem_ctl_pkg::WAIT_OFS) begin
         wait_sec_ff <= wdata_i[SW-1:0];
      end
   end

   // sticky carrier-lost flag; a new alarm wins over a write-one clear
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lost_ff <= 1'b0;
      end else if (alarm_ff) begin
         lost_ff <= 1'b1;
      end else if (wr_i && addr_i == modem_ctl_pkg::STAT_OFS && wdata_i[modem_ctl_pkg::STAT_LOST_BIT]) begin
         lost_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff <= 32'h0;
      end else if (rd_i) begin
         rdata_ff <= 32'h0;
         unique case (addr_i)
            modem_ctl_pkg::CTRL_OFS: begin
               rdata_ff[modem_ctl_pkg::CTRL_MODEM_BIT] <= modem_mode_ff;
               rdata_ff[modem_ctl_pkg::CTRL_SBMODE_BIT] <= sb_mode_ff;
               rdata_ff[modem_ctl_pkg::CTRL_SBACT_BIT] <= sb_act_ff;
            end
            modem_ctl_pkg::WAIT_OFS: begin
               rdata_ff[SW-1:0] <= wait_sec_ff;
            end
            modem_ctl_pkg::STAT_OFS: begin
               rdata_ff[modem_ctl_pkg::STAT_DTR_BIT] <= dtr_o;
               rdata_ff[modem_ctl_pkg::STAT_RTS_BIT] <= rts_o;
               rdata_ff[modem_ctl_pkg::STAT_UP_BIT] <= link_up_o;
               rdata_ff[modem_ctl_pkg::STAT_LOST_BIT] <= lost_ff;
               rdata_ff[modem_ctl_pkg::STAT_STATE_LSB +: 2] <= state_ff;
               rdata_ff[modem_ctl_pkg::STAT_CD_BIT] <= cd_s;
               rdata_ff[modem_ctl_pkg::STAT_DSR_BIT] <= dsr_s;
               rdata_ff[modem_ctl_pkg::STAT_RI_BIT] <= ri_s;
            end
            default: begin
               rdata_ff <= 32'h0;
            end
         endcase
      end
   end

   assign rdata_o = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // second timer

   logic sb_hold;
   logic cd_seen_ff;
   logic ri_restart;
   logic timer_clr;
   logic tick;
   logic [SW-1:0] sec_cnt_ff;
   logic hold_done;
   logic wait_done;

   assign sb_hold = sb_mode_ff && !sb_act_ff;
   assign ri_restart = state_ff == modem_ctl_pkg::ST_WAIT && modem_mode_ff && ri_rise && !cd_seen_ff;
   // restarting the tick too makes every interval exact to the cycle
   assign timer_clr = (nxt_state != state_ff) || ri_restart || l2_timeout_i
      || (state_ff == modem_ctl_pkg::ST_UP && cd_edge);

   sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(timer_clr),
      .tick_o(tick)
   );

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sec_cnt_ff <= '0;
      end else if (timer_clr) begin
         sec_cnt_ff <= '0;
      end else if (tick && sec_cnt_ff != modem_ctl_pkg::SEC_MAX) begin
         sec_cnt_ff <= sec_cnt_ff + SW'(1);
      end
   end

   assign hold_done = sec_cnt_ff >= modem_ctl_pkg::HOLD_SEC;
   assign wait_done = sec_cnt_ff >= wait_sec_ff;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cd_seen_ff <= 1'b0;
      end else if (state_ff != modem_ctl_pkg::ST_WAIT) begin
         cd_seen_ff <= 1'b0;
      end else if (cd_s) begin
         cd_seen_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         modem_ctl_pkg::ST_LOW: begin
            if (sb_hold) begin
               nxt_state = modem_ctl_pkg::ST_STANDBY;
            end else if (modem_mode_ff && ri_rise) begin
               nxt_state = modem_ctl_pkg::ST_WAIT;
            end else if (hold_done && !l2_timeout_i) begin
               nxt_state = modem_ctl_pkg::ST_WAIT;
            end
         end
         modem_ctl_pkg::ST_WAIT: begin
            if (sb_hold) begin
               nxt_state = modem_ctl_pkg::ST_STANDBY;
            end else if (l2_timeout_i) begin
               nxt_state = modem_ctl_pkg::ST_LOW;
            end else if (cd_s && dsr_s) begin
               nxt_state = modem_ctl_pkg::ST_UP;
            end else if (wait_done && !cd_s && !ri_restart) begin
               nxt_state = modem_ctl_pkg::ST_LOW;
            end
         end
         modem_ctl_pkg::ST_UP: begin
            // carrier loss only alarms; the link stays up for sending
            if (sb_hold) begin
               nxt_state = modem_ctl_pkg::ST_STANDBY;
            end else if (l2_timeout_i) begin
               nxt_state = modem_ctl_pkg::ST_LOW;
            end
         end
         modem_ctl_pkg::ST_STANDBY: begin
            if (!sb_hold) begin
               nxt_state = modem_ctl_pkg::ST_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= modem_ctl_pkg::ST_LOW;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   logic dtr_ff;
   logic up_ff;
   logic alarm_done_ff;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dtr_ff <= 1'b0;
         up_ff <= 1'b0;
      end else begin
         dtr_ff <= nxt_state == modem_ctl_pkg::ST_WAIT || nxt_state == modem_ctl_pkg::ST_UP;
         up_ff <= nxt_state == modem_ctl_pkg::ST_UP;
      end
   end

   // one single-cycle alarm pulse per loss; rearmed once carrier returns
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alarm_ff <= 1'b0;
         alarm_done_ff <= 1'b0;
      end else if (state_ff != modem_ctl_pkg::ST_UP || cd_s) begin
         alarm_ff <= 1'b0;
         alarm_done_ff <= 1'b0;
      end else if (sec_cnt_ff == modem_ctl_pkg::LOSS_SEC && !alarm_done_ff && !cd_edge) begin
         alarm_ff <= 1'b1;
         alarm_done_ff <= 1'b1;
      end else begin
         alarm_ff <= 1'b0;
      end
   end

   assign dtr_o = dtr_ff;
   assign rts_o = dtr_ff;
   // no clear-to-send gating anywhere on the send path
   assign link_up_o = up_ff;
   assign alarm_o = alarm_ff;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_ri_answer_low: assert property (
      state_ff == modem_ctl_pkg::ST_LOW && modem_mode_ff && ri_rise && !sb_hold
      |=> state_ff == modem_ctl_pkg::ST_WAIT && dtr_o && rts_o && sec_cnt_ff == '0)
      else $error("ri in low did not raise dtr at once");

   a_wait_exit_cause: assert property (
      state_ff == modem_ctl_pkg::ST_WAIT ##1 state_ff == modem_ctl_pkg::ST_LOW
      |-> $past(l2_timeout_i) || ($past(wait_done) && !$past(cd_s)))
      else $error("wait left for low without timeout");

   a_dataset_ri_ignored: assert property (
      state_ff == modem_ctl_pkg::ST_LOW && !modem_mode_ff && !hold_done && !sb_hold
      |=> state_ff == modem_ctl_pkg::ST_LOW && !dtr_o)
      else $error("dataset mode reacted to ri");

   a_hold_low_time: assert property (
      state_ff == modem_ctl_pkg::ST_LOW ##1 state_ff == modem_ctl_pkg::ST_WAIT
      |-> $past(hold_done) || ($past(ri_rise) && $past(modem_mode_ff)))
      else $error("low hold cut short");

   a_l2_toggle: assert property (
      l2_timeout_i && !sb_hold && state_ff != modem_ctl_pkg::ST_STANDBY
      |=> state_ff == modem_ctl_pkg::ST_LOW ##1 !dtr_o)
      else $error("level 2 timeout did not drop dtr");

   a_up_needs_both: assert property (
      $rose(link_up_o) |-> $past(cd_s && dsr_s, 1))
      else $error("link up without cd and dsr");

   a_alarm_after_loss: assert property (
      alarm_o |-> $past(sec_cnt_ff) == modem_ctl_pkg::LOSS_SEC && !$past(cd_s) && link_up_o)
      else $error("alarm not at ten seconds of loss");

   a_loss_stays_up: assert property (
      link_up_o && !cd_s && !l2_timeout_i && !sb_hold |=> link_up_o)
      else $error("carrier loss took link down");

   a_ri_restart_wait: assert property (
      ri_restart && !sb_hold && !l2_timeout_i && !(cd_s && dsr_s)
      |=> sec_cnt_ff == '0 && state_ff == modem_ctl_pkg::ST_WAIT)
      else $error("ri did not restart wait timer");

   a_ri_after_cd: assert property (
      state_ff == modem_ctl_pkg::ST_WAIT && cd_seen_ff && nxt_state == state_ff && !l2_timeout_i
      |=> sec_cnt_ff >= $past(sec_cnt_ff))
      else $error("ri restarted timer after cd");

   a_standby_idle: assert property (
      state_ff == modem_ctl_pkg::ST_STANDBY |-> !dtr_o && !rts_o)
      else $error("standby link not idle");

   a_standby_call: assert property (
      state_ff == modem_ctl_pkg::ST_STANDBY && !sb_hold |=> dtr_o && rts_o)
      else $error("activation did not raise dtr");

   c_link_up: cover property (state_ff == modem_ctl_pkg::ST_WAIT ##1 state_ff == modem_ctl_pkg::ST_UP);
   c_wait_timeout: cover property (state_ff == modem_ctl_pkg::ST_WAIT && wait_done && !cd_s);
   c_carrier_alarm: cover property (alarm_o);
   c_standby_call: cover property (state_ff == modem_ctl_pkg::ST_STANDBY ##1 state_ff == modem_ctl_pkg::ST_WAIT);

endmodule : modem_ctl

// ---- modem_ctl_pkg.sv ----
// constants, register map and state codes for the wan modem control sequencer
package modem_ctl_pkg;

   // system clock
   localparam int CLK_HZ = 250_000_000;
   localparam int TICK_SEC = 1;
   localparam int TICK_CYCLES = TICK_SEC * CLK_HZ;

   // timer figures, counted in one-second ticks
   localparam int SEC_W = 8;
   localparam logic [SEC_W-1:0] WAIT_SEC_RST = 8'h3c;
   localparam logic [SEC_W-1:0] HOLD_SEC = 8'h05;
   localparam logic [SEC_W-1:0] LOSS_SEC = 8'h0a;
   localparam logic [SEC_W-1:0] SEC_MAX = 8'hff;

   // register bus
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] WAIT_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;

   // ctrl fields
   localparam int CTRL_MODEM_BIT = 0;
   localparam int CTRL_SBMODE_BIT = 1;
   localparam int CTRL_SBACT_BIT = 2;
   localparam logic CTRL_MODEM_RST = 1'b1;
   localparam logic CTRL_SBMODE_RST = 1'b0;
   localparam logic CTRL_SBACT_RST = 1'b0;

   // status fields
   localparam int STAT_DTR_BIT = 0;
   localparam int STAT_RTS_BIT = 1;
   localparam int STAT_UP_BIT = 2;
   localparam int STAT_LOST_BIT = 3;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_CD_BIT = 6;
   localparam int STAT_DSR_BIT = 7;
   localparam int STAT_RI_BIT = 8;

   // sequencer states, gray along low -> wait -> up
   typedef enum logic [1:0] {
      ST_LOW = 2'b00,
      ST_WAIT = 2'b01,
      ST_UP = 2'b11,
      ST_STANDBY = 2'b10
   } link_state_t;

endpackage : modem_ctl_pkg

// ---- sync2.sv ----
// two-flop synchroniser for a group of pin levels
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d_i;
         q_ff <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule : sync2

// ---- sec_tick.sv ----
// one-second tick generator, restartable so timers start exactly at an event
module sec_tick #(
   parameter int CYCLES = modem_ctl_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clear_i,
   output logic tick_o
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_ff;
   logic tick_ff;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (clear_i) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (cnt_ff == LAST) begin
         cnt_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + CW'(1);
         tick_ff <= 1'b0;
      end
   end

   assign tick_o = tick_ff;

endmodule : sec_tick

// ---- modem_model.sv ----
// behavioural modem facing the sequencer's control pins
module modem_model #(
   parameter int DELAY = 12,
   parameter int LAG = 20
) (
   input wire logic clk_i,
   input wire logic dtr_i,
   input wire logic rts_i,
   input wire logic ring_i,
   input wire logic answer_i,
   input wire logic cd_cut_i,
   output logic ri_o,
   output logic cd_o,
   output logic dsr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   initial cnt = 0;
   ////////////////////////////////////////////////////////////////////////
   // ring level is commanded by the bench directly
   assign ri_o = ring_i;
   // dsr lags carrier so a carrier-only link-up shows as early
   assign cd_o = (cnt >= DELAY) && !cd_cut_i;
   assign dsr_o = cnt >= LAG;
   always @(posedge clk_i) begin
      if (!(dtr_i && rts_i)) begin
         cnt <= 0;
      end else if (answer_i && cnt < LAG) begin
         cnt <= cnt + 1;
      end
   end
endmodule : modem_model

// ---- test_wan_modem_control_handshake.sv ----
// self-checking bench for the wan modem control sequencer
module test_wan_modem_control_handshake;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 8;
   logic clk_i, reset_n_i, l2_timeout_i, wr_i, rd_i;
   logic [3:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic ri, cd, dsr, dtr_o, rts_o, link_up_o, alarm_o, ring, answer, cd_cut;
   int fails, compares, alarms;
   modem_ctl #(.TICK_CYCLES(T)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ri_i(ri), .cd_i(cd),
      .dsr_i(dsr), .l2_timeout_i(l2_timeout_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .dtr_o(dtr_o), .rts_o(rts_o), .link_up_o(link_up_o),
      .alarm_o(alarm_o));
   modem_model i_modem (.clk_i(clk_i), .dtr_i(dtr_o), .rts_i(rts_o), .ring_i(ring),
      .answer_i(answer), .cd_cut_i(cd_cut), .ri_o(ri), .cd_o(cd), .dsr_o(dsr));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // counted mid-cycle so a check at the next rising edge never races the count
   always @(negedge clk_i) if (alarm_o === 1'b1) alarms++;
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   function automatic logic seen(input int s, input logic lvl);
      return s == 0 ? (dtr_o === lvl && rts_o === lvl) : (link_up_o === lvl);
   endfunction : seen
   // edge must land in [lo, hi) cycles; running out ends the run
   task automatic edge_in(input int s, input logic lvl, input int lo, input int hi);
      int i;
      #1;
      for (i = 0; i < hi; i++) begin
         if (seen(s, lvl)) break;
         @(posedge clk_i);
         #1;
      end
      compares++;
      if (i < lo || i >= hi) begin
         fails++;
         $display("[ERR] %0t signal %0d to %b after %0d cycles", $time, s, lvl, i);
         if (i >= hi) results();
      end
   endtask : edge_in
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp, "read");
   endtask : rd
   task automatic ring_pulse();
      @(posedge clk_i);
      ring <= 1'b1;
      repeat (3) @(posedge clk_i);
      ring <= 1'b0;
   endtask : ring_pulse
   task automatic do_reset();
      reset_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(4'h0, 32'h0000_0001);
      rd(4'h4, 32'h0000_003c);
      rd(4'h8, 32'h0000_0000);
      rd(4'hc, 32'h0000_0000);
      wr(4'hc, 32'hffff_ffff);
      rd(4'h0, 32'h0000_0001);
      wr(4'h4, 32'h0000_0002);
      rd(4'h4, 32'h0000_0002);
   endtask : t_regs
   task automatic t_toggle();
      wr(4'h4, 32'h0000_0002);
      edge_in(0, 1'b1, 5*T-8, 5*T+4);
      edge_in(0, 1'b0, 2*T-4, 2*T+4);
      edge_in(0, 1'b1, 5*T-4, 5*T+4);
   endtask : t_toggle
   task automatic t_ring();
      edge_in(0, 1'b0, 0, 3*T);
      repeat (T) @(posedge clk_i);
      ring_pulse();
      edge_in(0, 1'b1, 0, 4);
      repeat (T) @(posedge clk_i);
      ring_pulse();
      edge_in(0, 1'b0, 2*T-8, 2*T+4);
   endtask : t_ring
   task automatic t_link();
      answer <= 1'b1;
      edge_in(0, 1'b1, 0, 6*T);
      edge_in(1, 1'b1, 20, 30);
      ring_pulse();
      repeat (4) @(posedge clk_i);
      rd(4'h8, 32'h0000_00f7);
      cd_cut <= 1'b1;
      repeat (9*T) @(posedge clk_i);
      cd_cut <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(alarms, 0, "short drop");
      cd_cut <= 1'b1;
      repeat (10*T+6) @(posedge clk_i);
      cd_cut <= 1'b0;
      chk(alarms, 1, "long drop");
      chk({dtr_o, link_up_o}, 2'b11, "kept up");
      repeat (4) @(posedge clk_i);
      rd(4'h8, 32'h0000_00ff);
      wr(4'h8, 32'h0000_0008);
      rd(4'h8, 32'h0000_00f7);
   endtask : t_link
   task automatic t_l2();
      answer <= 1'b0;
      @(posedge clk_i);
      l2_timeout_i <= 1'b1;
      @(posedge clk_i);
      l2_timeout_i <= 1'b0;
      edge_in(1, 1'b0, 0, 3);
      edge_in(0, 1'b1, 5*T-4, 5*T+4);
   endtask : t_l2
   task automatic t_dataset();
      wr(4'h0, 32'h0000_0000);
      edge_in(0, 1'b0, 0, 3*T);
      ring_pulse();
      repeat (4) @(posedge clk_i);
      chk(dtr_o, 1'b0, "ring ignored");
      answer <= 1'b1;
      edge_in(0, 1'b1, 0, 6*T);
      edge_in(1, 1'b1, 20, 30);
   endtask : t_dataset
   task automatic t_standby();
      wr(4'h0, 32'h0000_0003);
      edge_in(0, 1'b0, 0, 4);
      repeat (8*T) @(posedge clk_i);
      rd(4'h8, 32'h0000_0020);
      wr(4'h0, 32'h0000_0007);
      edge_in(0, 1'b1, 0, 4);
      edge_in(1, 1'b1, 20, 30);
   endtask : t_standby
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n_i = 1'b0;
      l2_timeout_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 32'h0000_0000;
      ring = 1'b0;
      answer = 1'b0;
      cd_cut = 1'b0;
      fails = 0;
      compares = 0;
      alarms = 0;
      do_reset();
      t_regs();
      // second reset restarts the hold timing from a known point
      do_reset();
      t_toggle();
      t_ring();
      t_link();
      t_l2();
      t_dataset();
      t_standby();
      results();
   end
endmodule : test_wan_modem_control_handshake
